// file: hw/flash_seq_pkg.sv
package flash_seq_pkg;
	// clock and timing base
	localparam int CLK_NS = 5;
	localparam int NS_PER_US = 1000;
	localparam int NS_PER_MS = 1000000;
	// wait times in microseconds or milliseconds
	localparam int SSWE_US = 1;
	localparam int SPSU_US = 50;
	localparam int SP10_US = 10;
	localparam int SP30_US = 30;
	localparam int SP200_US = 200;
	localparam int CP_US = 5;
	localparam int CPSU_US = 5;
	localparam int SPV_US = 4;
	localparam int SPVR_US = 2;
	localparam int CPV_US = 2;
	localparam int HVCSWE_US = 100;
	localparam int SESU_US = 100;
	localparam int SE_SHORT_MS = 10;
	localparam int SE_LONG_MS = 100;
	localparam int CE_US = 10;
	localparam int CESU_US = 10;
	localparam int SEV_US = 20;
	localparam int CEV_US = 4;
	// least waits in cycles, rounded up
	localparam int SSWE_CYC = (SSWE_US * NS_PER_US + CLK_NS - 1) / CLK_NS;
	localparam int SP10_CYC = (SP10_US * NS_PER_US + CLK_NS - 1) / CLK_NS;
	localparam int CP_CYC = (CP_US * NS_PER_US + CLK_NS - 1) / CLK_NS;
	localparam int CPSU_CYC = (CPSU_US * NS_PER_US + CLK_NS - 1) / CLK_NS;
	localparam int SPV_CYC = (SPV_US * NS_PER_US + CLK_NS - 1) / CLK_NS;
	localparam int SPVR_CYC = (SPVR_US * NS_PER_US + CLK_NS - 1) / CLK_NS;
	localparam int CPV_CYC = (CPV_US * NS_PER_US + CLK_NS - 1) / CLK_NS;
	localparam int CE_CYC = (CE_US * NS_PER_US + CLK_NS - 1) / CLK_NS;
	localparam int CESU_CYC = (CESU_US * NS_PER_US + CLK_NS - 1) / CLK_NS;
	localparam int SEV_CYC = (SEV_US * NS_PER_US + CLK_NS - 1) / CLK_NS;
	localparam int CEV_CYC = (CEV_US * NS_PER_US + CLK_NS - 1) / CLK_NS;
	// pin input synchroniser latency plus capture
	localparam int SYNC_CYC = 3;
	// loop limits and unit size
	localparam logic [9:0] PROG_MAX_CNT = 10'd1000;
	localparam logic [9:0] SHORT_PULSE_CNT = 10'd6;
	localparam logic [9:0] ERASE_MAX_SHORT = 10'd120;
	localparam logic [9:0] ERASE_MAX_LONG = 10'd12;
	localparam logic [6:0] UNIT_LAST = 7'h7f;
	localparam logic [7:0] DUMMY_BYTE = 8'hff;
	localparam logic [7:0] ERASED_BYTE = 8'hff;
	// register byte offsets and fields
	localparam logic [5:0] REG_CTRL = 6'h00;
	localparam logic [5:0] REG_STAT = 6'h04;
	localparam logic [5:0] REG_ADDR = 6'h08;
	localparam logic [5:0] REG_DATA = 6'h0c;
	localparam int CTRL_START = 0;
	localparam int CTRL_ERASE = 1;
	localparam int CTRL_EXTRA = 2;
	localparam int CTRL_LONG = 3;
	localparam int STAT_BUSY = 0;
	localparam int STAT_DONE = 1;
	localparam int STAT_ERR = 2;
	localparam int STAT_CNT_LSB = 16;
	localparam logic WAITREQ_RST = 1'b1;
	// sequencer states
	typedef enum logic [3:0] {
		S_IDLE, S_WEN_ON, S_FILL, S_SETUP, S_PULSE, S_PCLR, S_SCLR,
		S_VON, S_DUMMY, S_READ, S_VOFF, S_WEN_OFF
	} flash_state_t;
	// pins toward the flash array
	typedef struct packed {
		logic software_write_enable;
		logic program_setup_bit;
		logic program_pulse_bit;
		logic writing_chk_bit;
		logic erase_setup_bit;
		logic erase_pulse_bit;
		logic erase_verify_bit;
		logic wr;
		logic rd;
		logic [15:0] addr;
		logic [7:0] wdata;
	} flash_pins_t;
endpackage : flash_seq_pkg

// file: hw/flash_seq.sv
`timescale 1ns/1ps
module flash_seq #(
	parameter int SPSU_CYC = (flash_seq_pkg::SPSU_US * flash_seq_pkg::NS_PER_US
		+ flash_seq_pkg::CLK_NS - 1) / flash_seq_pkg::CLK_NS,
	parameter int SP30_CYC = (flash_seq_pkg::SP30_US * flash_seq_pkg::NS_PER_US
		+ flash_seq_pkg::CLK_NS - 1) / flash_seq_pkg::CLK_NS,
	parameter int SP200_CYC = (flash_seq_pkg::SP200_US * flash_seq_pkg::NS_PER_US
		+ flash_seq_pkg::CLK_NS - 1) / flash_seq_pkg::CLK_NS,
	parameter int HVCSWE_CYC = (flash_seq_pkg::HVCSWE_US * flash_seq_pkg::NS_PER_US
		+ flash_seq_pkg::CLK_NS - 1) / flash_seq_pkg::CLK_NS,
	parameter int SESU_CYC = (flash_seq_pkg::SESU_US * flash_seq_pkg::NS_PER_US
		+ flash_seq_pkg::CLK_NS - 1) / flash_seq_pkg::CLK_NS,
	parameter int SE_SHORT_CYC = (flash_seq_pkg::SE_SHORT_MS * flash_seq_pkg::NS_PER_MS
		+ flash_seq_pkg::CLK_NS - 1) / flash_seq_pkg::CLK_NS,
	parameter int SE_LONG_CYC = (flash_seq_pkg::SE_LONG_MS * flash_seq_pkg::NS_PER_MS
		+ flash_seq_pkg::CLK_NS - 1) / flash_seq_pkg::CLK_NS
) (
	// clock and reset
	input wire logic CLK_IN,
	input wire logic RST_N_IN,
	// avalon-mm slave
	input wire logic [3:0] AVS_ADDRESS_IN,
	input wire logic AVS_READ_IN,
	input wire logic AVS_WRITE_IN,
	input wire logic [31:0] AVS_WRITEDATA_IN,
	output logic [31:0] AVS_READDATA_OUT,
	output logic AVS_WAITREQUEST_OUT,
	// flash array side
	output flash_seq_pkg::flash_pins_t FLASH_PINS_OUT,
	input wire logic [7:0] FLASH_RDATA_IN
);
	import flash_seq_pkg::*;

	// whole module state
	typedef struct packed {
		flash_state_t st;
		logic [31:0] tmr;      // wait countdown
		logic [9:0] cnt;       // pulse loop count
		logic [6:0] idx;       // byte within unit
		logic add;             // additional pulse in flight
		logic add_done;        // additional pulse already given
		logic pass;            // verify still clean
		logic erase;           // erase mode
		logic extra;           // additional programming enable
		logic long_pulse;      // 100 ms erase pulse
		logic [15:0] base;     // unit or block base address
		logic [7:0] pdata;     // byte to program
		logic busy;
		logic done;
		logic err;
		flash_pins_t pins;
		logic [7:0] rs1;       // synchroniser stage one
		logic [7:0] rs2;       // synchroniser stage two
		logic ack;             // bus answer cycle
		logic waitreq;
		logic [31:0] rdata;
	} seq_t;

	seq_t s_ff;
	seq_t nxt_s;
	logic [5:0] byte_addr;     // bus byte address
	logic start;               // accepted start command
	logic miss;                // verify byte mismatch
	logic [9:0] max_cnt;       // loop limit for this mode
	logic [7:0] expect_byte;   // verify reference

	// enter a state with a wait of c cycles
	function automatic seq_t go(input seq_t x, input flash_state_t st, input int c);
		seq_t y;
		y = x;
		y.st = st;
		y.tmr = 32'(c - 1);
		return y;
	endfunction : go

	assign byte_addr = {AVS_ADDRESS_IN, 2'b00};
	assign expect_byte = s_ff.erase ? ERASED_BYTE : s_ff.pdata;
	assign miss = s_ff.rs2 != expect_byte;
	// erase count tied to pulse length, product fixed
	assign max_cnt = !s_ff.erase ? PROG_MAX_CNT :
		(s_ff.long_pulse ? ERASE_MAX_LONG : ERASE_MAX_SHORT);

	// next state: bus slave then sequencer
	always_comb begin
		nxt_s = s_ff;
		start = 1'b0;
		nxt_s.rs1 = FLASH_RDATA_IN;
		nxt_s.rs2 = s_ff.rs1;
		// one wait cycle, then answer
		if ((AVS_READ_IN || AVS_WRITE_IN) && !s_ff.ack) begin
			nxt_s.ack = 1'b1;
			nxt_s.waitreq = 1'b0;
			case (byte_addr)
				REG_CTRL: nxt_s.rdata = {28'h0, s_ff.long_pulse, s_ff.extra, s_ff.erase, 1'b0};
				REG_STAT: nxt_s.rdata = {6'h0, s_ff.cnt, 13'h0, s_ff.err, s_ff.done, s_ff.busy};
				REG_ADDR: nxt_s.rdata = {16'h0, s_ff.base};
				REG_DATA: nxt_s.rdata = {24'h0, s_ff.pdata};
				default: nxt_s.rdata = 32'h0;
			endcase
		end else begin
			nxt_s.ack = 1'b0;
			nxt_s.waitreq = 1'b1;
		end
		// writes take effect at the edge that sees waitrequest low
		if (AVS_WRITE_IN && s_ff.ack && !s_ff.busy) begin
			case (byte_addr)
				REG_CTRL: begin
					nxt_s.erase = AVS_WRITEDATA_IN[CTRL_ERASE];
					nxt_s.extra = AVS_WRITEDATA_IN[CTRL_EXTRA];
					nxt_s.long_pulse = AVS_WRITEDATA_IN[CTRL_LONG];
					start = AVS_WRITEDATA_IN[CTRL_START];
				end
				REG_ADDR: nxt_s.base = AVS_WRITEDATA_IN[15:0];
				REG_DATA: nxt_s.pdata = AVS_WRITEDATA_IN[7:0];
				default: nxt_s.base = s_ff.base;
			endcase
		end
		// strobes last one cycle
		nxt_s.pins.wr = 1'b0;
		nxt_s.pins.rd = 1'b0;
		if (s_ff.tmr != 32'h0) begin
			nxt_s.tmr = s_ff.tmr - 32'h1;
		end
		case (s_ff.st)
			// wait for a start command
			S_IDLE: begin
				if (start) begin
					nxt_s.busy = 1'b1;
					nxt_s.done = 1'b0;
					nxt_s.err = 1'b0;
					nxt_s.cnt = 10'h0;
					nxt_s.add = 1'b0;
					nxt_s.add_done = 1'b0;
					nxt_s.pins.software_write_enable = 1'b1;
					nxt_s = go(nxt_s, S_WEN_ON, SSWE_CYC);
				end
			end
			// write enable settling
			S_WEN_ON: begin
				if (s_ff.tmr == 32'h0) begin
					nxt_s.idx = 7'h0;
					if (s_ff.erase) begin
						nxt_s.pins.erase_setup_bit = 1'b1;
						nxt_s = go(nxt_s, S_SETUP, SESU_CYC);
					end else begin
						nxt_s = go(nxt_s, S_FILL, 1);
					end
				end
			end
			// load the 128-byte unit
			S_FILL: begin
				if (!s_ff.pins.wr) begin
					nxt_s.pins.wr = 1'b1;
					nxt_s.pins.addr = s_ff.base | {9'h0, s_ff.idx};
					nxt_s.pins.wdata = s_ff.pdata;
				end else if (s_ff.idx == UNIT_LAST) begin
					nxt_s.pins.program_setup_bit = 1'b1;
					nxt_s = go(nxt_s, S_SETUP, SPSU_CYC);
				end else begin
					nxt_s.idx = s_ff.idx + 7'h1;
				end
			end
			// setup settling, then the pulse
			S_SETUP: begin
				if (s_ff.tmr == 32'h0) begin
					if (s_ff.erase) begin
						nxt_s.cnt = s_ff.cnt + 10'h1;
						nxt_s.pins.erase_pulse_bit = 1'b1;
						nxt_s = go(nxt_s, S_PULSE,
							s_ff.long_pulse ? SE_LONG_CYC : SE_SHORT_CYC);
					end else if (s_ff.add) begin
						nxt_s.pins.program_pulse_bit = 1'b1;
						nxt_s = go(nxt_s, S_PULSE, SP10_CYC);
					end else begin
						nxt_s.cnt = s_ff.cnt + 10'h1;
						nxt_s.pins.program_pulse_bit = 1'b1;
						nxt_s = go(nxt_s, S_PULSE,
							(s_ff.cnt < SHORT_PULSE_CNT) ? SP30_CYC : SP200_CYC);
					end
				end
			end
			// pulse running
			S_PULSE: begin
				if (s_ff.tmr == 32'h0) begin
					nxt_s.pins.program_pulse_bit = 1'b0;
					nxt_s.pins.erase_pulse_bit = 1'b0;
					nxt_s = go(nxt_s, S_PCLR, s_ff.erase ? CE_CYC : CP_CYC);
				end
			end
			// after pulse clear, drop setup
			S_PCLR: begin
				if (s_ff.tmr == 32'h0) begin
					nxt_s.pins.program_setup_bit = 1'b0;
					nxt_s.pins.erase_setup_bit = 1'b0;
					nxt_s = go(nxt_s, S_SCLR, s_ff.erase ? CESU_CYC : CPSU_CYC);
				end
			end
			// after setup clear, verify or finish
			S_SCLR: begin
				if (s_ff.tmr == 32'h0) begin
					if (s_ff.add) begin
						nxt_s.add = 1'b0;
						nxt_s.add_done = 1'b1;
						nxt_s.pins.software_write_enable = 1'b0;
						nxt_s = go(nxt_s, S_WEN_OFF, HVCSWE_CYC);
					end else begin
						nxt_s.idx = 7'h0;
						nxt_s.pass = 1'b1;
						nxt_s.pins.writing_chk_bit = !s_ff.erase;
						nxt_s.pins.erase_verify_bit = s_ff.erase;
						nxt_s = go(nxt_s, S_VON, s_ff.erase ? SEV_CYC : SPV_CYC);
					end
				end
			end
			// verify settling, then first dummy write
			S_VON: begin
				if (s_ff.tmr == 32'h0) begin
					nxt_s.pins.wr = 1'b1;
					nxt_s.pins.addr = s_ff.base | {9'h0, s_ff.idx};
					nxt_s.pins.wdata = DUMMY_BYTE;
					nxt_s = go(nxt_s, S_DUMMY, SPVR_CYC);
				end
			end
			// dummy write done, read after the wait
			S_DUMMY: begin
				if (s_ff.tmr == 32'h0) begin
					nxt_s.pins.rd = 1'b1;
					nxt_s = go(nxt_s, S_READ, SYNC_CYC);
				end
			end
			// compare synchronised byte
			S_READ: begin
				if (s_ff.tmr == 32'h0) begin
					nxt_s.pass = s_ff.pass && !miss;
					if (s_ff.idx == UNIT_LAST) begin
						nxt_s.pins.writing_chk_bit = 1'b0;
						nxt_s.pins.erase_verify_bit = 1'b0;
						nxt_s = go(nxt_s, S_VOFF, s_ff.erase ? CEV_CYC : CPV_CYC);
					end else begin
						nxt_s.idx = s_ff.idx + 7'h1;
						nxt_s.pins.wr = 1'b1;
						nxt_s.pins.addr = s_ff.base | {9'h0, s_ff.idx + 7'h1};
						nxt_s.pins.wdata = DUMMY_BYTE;
						nxt_s = go(nxt_s, S_DUMMY, SPVR_CYC);
					end
				end
			end
			// decide: done, extra pulse, retry or give up
			S_VOFF: begin
				if (s_ff.tmr == 32'h0) begin
					if (s_ff.pass && !s_ff.erase && s_ff.extra && !s_ff.add_done
						&& s_ff.cnt <= SHORT_PULSE_CNT) begin
						nxt_s.add = 1'b1;
						nxt_s.pins.program_setup_bit = 1'b1;
						nxt_s = go(nxt_s, S_SETUP, SPSU_CYC);
					end else if (s_ff.pass || s_ff.cnt >= max_cnt) begin
						nxt_s.err = !s_ff.pass;
						nxt_s.pins.software_write_enable = 1'b0;
						nxt_s = go(nxt_s, S_WEN_OFF, HVCSWE_CYC);
					end else if (s_ff.erase) begin
						nxt_s.pins.erase_setup_bit = 1'b1;
						nxt_s = go(nxt_s, S_SETUP, SESU_CYC);
					end else begin
						nxt_s.pins.program_setup_bit = 1'b1;
						nxt_s = go(nxt_s, S_SETUP, SPSU_CYC);
					end
				end
			end
			// write enable recovery before going idle
			S_WEN_OFF: begin
				if (s_ff.tmr == 32'h0) begin
					nxt_s.busy = 1'b0;
					nxt_s.done = 1'b1;
					nxt_s.st = S_IDLE;
				end
			end
			default: nxt_s.st = S_IDLE;
		endcase
	end

	// state register, synchronous reset
	always_ff @(posedge CLK_IN) begin
		if (!RST_N_IN) begin
			s_ff <= '0;
			s_ff.waitreq <= WAITREQ_RST;
		end else begin
			s_ff <= nxt_s;
		end
	end

	assign AVS_READDATA_OUT = s_ff.rdata;
	assign AVS_WAITREQUEST_OUT = s_ff.waitreq;
	assign FLASH_PINS_OUT = s_ff.pins;

	// helper: cycles since last control bit change and since last write
	logic [6:0] ctl_now;
	logic [6:0] ctl_nxt;
	logic [31:0] age_ff;
	logic [31:0] wage_ff;
	// the seven control levels sit at the top of the 33-bit pin word
	assign ctl_now = s_ff.pins[32:26];
	assign ctl_nxt = nxt_s.pins[32:26];
	always_ff @(posedge CLK_IN) begin
		if (!RST_N_IN) begin
			age_ff <= 32'h0;
			wage_ff <= 32'h0;
		end else begin
			age_ff <= (ctl_nxt != ctl_now) ? 32'h0 : age_ff + 32'h1;
			wage_ff <= nxt_s.pins.wr ? 32'h0 : wage_ff + 32'h1;
		end
	end

	property p_wen_wait;
		@(posedge CLK_IN) disable iff (!RST_N_IN)
		$rose(s_ff.pins.program_setup_bit) || $rose(s_ff.pins.erase_setup_bit)
			|-> $past(age_ff) + 32'h1 >= 32'(SSWE_CYC);
	endproperty
	a_wen_wait: assert property (p_wen_wait) else $error("setup too soon after enable");
	property p_pset_wait;
		@(posedge CLK_IN) disable iff (!RST_N_IN)
		$rose(s_ff.pins.program_pulse_bit) |-> $past(age_ff) + 32'h1 == 32'(SPSU_CYC);
	endproperty
	a_pset_wait: assert property (p_pset_wait) else $error("program pulse early");
	property p_short_pulse;
		@(posedge CLK_IN) disable iff (!RST_N_IN)
		$fell(s_ff.pins.program_pulse_bit) && !s_ff.add && s_ff.cnt <= SHORT_PULSE_CNT
			|-> $past(age_ff) + 32'h1 == 32'(SP30_CYC);
	endproperty
	a_short_pulse: assert property (p_short_pulse) else $error("pulse not 30 us");
	property p_add_pulse;
		@(posedge CLK_IN) disable iff (!RST_N_IN)
		$fell(s_ff.pins.program_pulse_bit) && s_ff.add
			|-> $past(age_ff) + 32'h1 == 32'(SP10_CYC);
	endproperty
	a_add_pulse: assert property (p_add_pulse) else $error("additional pulse length");
	property p_cp_wait;
		@(posedge CLK_IN) disable iff (!RST_N_IN)
		$fell(s_ff.pins.program_setup_bit) |-> $past(age_ff) + 32'h1 >= 32'(CP_CYC);
	endproperty
	a_cp_wait: assert property (p_cp_wait) else $error("setup cleared too soon");
	property p_read_after_dummy;
		@(posedge CLK_IN) disable iff (!RST_N_IN)
		$rose(s_ff.pins.rd) |-> $past(wage_ff) + 32'h1 == 32'(SPVR_CYC)
			&& $past(s_ff.pins.wdata) == DUMMY_BYTE;
	endproperty
	a_read_after_dummy: assert property (p_read_after_dummy) else $error("verify read");
	property p_wen_recover;
		@(posedge CLK_IN) disable iff (!RST_N_IN)
		$rose(s_ff.done) |-> $past(age_ff) + 32'h1 == 32'(HVCSWE_CYC)
			&& !s_ff.pins.software_write_enable;
	endproperty
	a_wen_recover: assert property (p_wen_recover) else $error("enable recovery");
	property p_loop_limit;
		@(posedge CLK_IN) disable iff (!RST_N_IN)
		s_ff.busy |-> s_ff.cnt <= max_cnt;
	endproperty
	a_loop_limit: assert property (p_loop_limit) else $error("pulse count over limit");
	property p_eset_wait;
		@(posedge CLK_IN) disable iff (!RST_N_IN)
		$rose(s_ff.pins.erase_pulse_bit) |-> $past(age_ff) + 32'h1 == 32'(SESU_CYC);
	endproperty
	a_eset_wait: assert property (p_eset_wait) else $error("erase pulse early");
	property p_ce_wait;
		@(posedge CLK_IN) disable iff (!RST_N_IN)
		$fell(s_ff.pins.erase_setup_bit) |-> $past(age_ff) + 32'h1 == 32'(CE_CYC);
	endproperty
	a_ce_wait: assert property (p_ce_wait) else $error("erase setup cleared early");

	c_prog: cover property (@(posedge CLK_IN) $rose(s_ff.done) && !s_ff.erase && !s_ff.err);
	c_erase: cover property (@(posedge CLK_IN) $rose(s_ff.done) && s_ff.erase);
	c_fail: cover property (@(posedge CLK_IN) $rose(s_ff.err));
	c_extra: cover property (@(posedge CLK_IN) $rose(s_ff.add));
endmodule : flash_seq

// file: tb/flash_model.sv
`timescale 1ns/1ps
// behavioural flash array that also measures the sequencer's waits
module flash_model
	import flash_seq_pkg::*;
#(
	parameter int SPSU = 20,
	parameter int P30 = 30,
	parameter int HVC = 25,
	parameter int SESU = 20
) (
	// clock and pins from the sequencer
	input wire logic clk_in,
	input wire flash_seq_pkg::flash_pins_t pins_in,
	// read data back to the sequencer
	output logic [7:0] rdata_out,
	// observation for the bench
	output logic [17:0] viol_out,
	output int n_pulse_out,
	output int n_fill_out,
	output int last_w_out
);
	logic [7:0] mem [0:127]; // array contents
	logic [7:0] wbuf [0:127]; // program buffer
	logic [7:0] pat; // filler while no read is held
	flash_pins_t prev_pins; // pins one cycle ago
	int cyc, t_wen_on, t_wen_off, t_pset_on, t_pset_off, t_p_on, t_p_off;
	int t_eset_on, t_eset_off, t_e_on, t_e_off, t_v_on, t_v_off, t_wr, t_rd, w;
	logic first; // next verify write is the first one
	logic last_erase_chk; // last verify was an erase verify
	// power-up state: unerased array
	initial begin
		cyc = 0;
		{t_wen_on, t_wen_off, t_pset_on, t_pset_off, t_p_on, t_p_off} = {6{-32'sd100000}};
		{t_eset_on, t_eset_off, t_e_on, t_e_off, t_v_on, t_v_off, t_wr} = {7{-32'sd100000}};
		t_rd = -100000;
		{viol_out, n_pulse_out, n_fill_out, last_w_out} = '0;
		{first, last_erase_chk, prev_pins, pat} = '0;
		for (int i = 0; i < 128; i++) mem[i] = 8'h00;
	end
	// read byte held from rd for three more cycles, else a changing pattern
	assign rdata_out = (pins_in.rd || cyc - t_rd <= 3) ? mem[pins_in.addr[6:0]] : pat;
	// edge watch on every control bit
	always @(posedge clk_in) begin
		cyc <= cyc + 1;
		pat <= ~pat;
		prev_pins <= pins_in;
		if (pins_in.software_write_enable && !prev_pins.software_write_enable) begin
			if (cyc - t_wen_off < HVC) viol_out[10] <= 1'b1;
			t_wen_on <= cyc;
			n_fill_out <= 0;
			n_pulse_out <= 0;
			for (int i = 0; i < 128; i++) wbuf[i] <= 8'hff;
		end
		if (!pins_in.software_write_enable && prev_pins.software_write_enable) begin
			if (last_erase_chk && cyc - t_v_off < CEV_CYC) viol_out[17] <= 1'b1;
			if (!last_erase_chk && cyc - t_v_off < CPV_CYC) viol_out[9] <= 1'b1;
			t_wen_off <= cyc;
		end
		if (pins_in.program_setup_bit && !prev_pins.program_setup_bit) begin
			if (cyc - t_wen_on < SSWE_CYC) viol_out[1] <= 1'b1;
			if (cyc - t_v_off < CPV_CYC) viol_out[9] <= 1'b1;
			t_pset_on <= cyc;
		end
		if (!pins_in.program_setup_bit && prev_pins.program_setup_bit) begin
			if (cyc - t_p_off < CP_CYC) viol_out[5] <= 1'b1;
			t_pset_off <= cyc;
		end
		if (pins_in.program_pulse_bit && !prev_pins.program_pulse_bit) begin
			if (cyc - t_pset_on < SPSU) viol_out[2] <= 1'b1;
			t_p_on <= cyc;
		end
		// pulse end: width check, then cells take the buffer
		if (!pins_in.program_pulse_bit && prev_pins.program_pulse_bit) begin
			w = cyc - t_p_on;
			if (n_pulse_out == 0 && (w < P30 || w > P30 + 1)) viol_out[3] <= 1'b1;
			last_w_out <= w;
			n_pulse_out <= n_pulse_out + 1;
			t_p_off <= cyc;
			for (int i = 0; i < 128; i++) mem[i] <= mem[i] & wbuf[i];
		end
		if (pins_in.writing_chk_bit && !prev_pins.writing_chk_bit) begin
			if (cyc - t_pset_off < CPSU_CYC) viol_out[6] <= 1'b1;
			{t_v_on, first, last_erase_chk} <= {cyc, 2'b10};
		end
		if (pins_in.erase_setup_bit && !prev_pins.erase_setup_bit) begin
			if (cyc - t_wen_on < SSWE_CYC) viol_out[1] <= 1'b1;
			t_eset_on <= cyc;
		end
		if (!pins_in.erase_setup_bit && prev_pins.erase_setup_bit) begin
			if (cyc - t_e_off < CE_CYC) viol_out[14] <= 1'b1;
			t_eset_off <= cyc;
		end
		if (pins_in.erase_pulse_bit && !prev_pins.erase_pulse_bit) begin
			if (cyc - t_eset_on < SESU) viol_out[12] <= 1'b1;
			t_e_on <= cyc;
		end
		// erase end: whole array reads erased
		if (!pins_in.erase_pulse_bit && prev_pins.erase_pulse_bit) begin
			last_w_out <= cyc - t_e_on;
			t_e_off <= cyc;
			for (int i = 0; i < 128; i++) mem[i] <= 8'hff;
		end
		if (pins_in.erase_verify_bit && !prev_pins.erase_verify_bit) begin
			if (cyc - t_eset_off < CESU_CYC) viol_out[15] <= 1'b1;
			{t_v_on, first, last_erase_chk} <= {cyc, 2'b11};
		end
		if ((!pins_in.writing_chk_bit && prev_pins.writing_chk_bit) ||
			(!pins_in.erase_verify_bit && prev_pins.erase_verify_bit)) t_v_off <= cyc;
		// fill write or verify dummy write
		if (pins_in.wr && !pins_in.writing_chk_bit && !pins_in.erase_verify_bit) begin
			if (cyc - t_wen_on < SSWE_CYC) viol_out[1] <= 1'b1;
			wbuf[pins_in.addr[6:0]] <= pins_in.wdata;
			n_fill_out <= n_fill_out + 1;
		end else if (pins_in.wr) begin
			if (pins_in.wdata !== 8'hff) viol_out[8] <= 1'b1;
			if (first && !last_erase_chk && cyc - t_v_on < SPV_CYC) viol_out[7] <= 1'b1;
			if (first && last_erase_chk && cyc - t_v_on < SEV_CYC) viol_out[16] <= 1'b1;
			{first, t_wr} <= {1'b0, cyc};
		end
		if (pins_in.rd) begin
			if (cyc - t_wr < SPVR_CYC) viol_out[8] <= 1'b1;
			t_rd <= cyc;
		end
	end
endmodule : flash_model

// file: tb/testbench.sv
`timescale 1ns/1ps
// self-checking bench for the flash sequencer
module testbench;
	import flash_seq_pkg::*;
	localparam int SPSU = 20, P30 = 30, P200 = 40, HVC = 25, SESU = 20, SES = 50, SEL = 60;
	logic clk, rst_n, read, write, waitreq; // bus and clocking
	logic [3:0] address; // word address
	logic [31:0] wdata, rdata; // bus data
	flash_pins_t pins; // sequencer to array
	logic [7:0] frd; // array read data
	logic [17:0] viol; // wait breaches seen by the array
	int n_pulse, n_fill, last_w, n_mismatch, compares;
	// design under test, shortened waits
	flash_seq #(.SPSU_CYC(SPSU), .SP30_CYC(P30), .SP200_CYC(P200), .HVCSWE_CYC(HVC),
		.SESU_CYC(SESU), .SE_SHORT_CYC(SES), .SE_LONG_CYC(SEL)) dut_u (
		.CLK_IN(clk), .RST_N_IN(rst_n), .AVS_ADDRESS_IN(address), .AVS_READ_IN(read),
		.AVS_WRITE_IN(write), .AVS_WRITEDATA_IN(wdata), .AVS_READDATA_OUT(rdata),
		.AVS_WAITREQUEST_OUT(waitreq), .FLASH_PINS_OUT(pins), .FLASH_RDATA_IN(frd));
	// array model
	flash_model #(.SPSU(SPSU), .P30(P30), .HVC(HVC), .SESU(SESU)) model_u (
		.clk_in(clk), .pins_in(pins), .rdata_out(frd), .viol_out(viol),
		.n_pulse_out(n_pulse), .n_fill_out(n_fill), .last_w_out(last_w));
	// compare and count
	task check(input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check
	// one avalon access, held until waitrequest is sampled low
	task bus(input logic wr, input logic [5:0] a, input logic [31:0] d, output logic [31:0] q);
		int n;
		n = 0;
		@(posedge clk);
		address <= a[5:2];
		wdata <= d;
		write <= wr;
		read <= !wr;
		do begin
			@(posedge clk);
			n++;
		end while (waitreq !== 1'b0 && n < 50);
		q = rdata;
		write <= 1'b0;
		read <= 1'b0;
		if (n >= 50) check(32'h1, 32'h0);
	endtask : bus
	// poll status until done
	task wait_done(output logic [31:0] s);
		s = '0;
		for (int k = 0; k < 60000 && s[STAT_DONE] !== 1'b1; k++) bus(1'b0, REG_STAT, '0, s);
	endtask : wait_done
	// reset values and an unmapped place
	task test_regs;
		logic [31:0] q;
		bus(1'b0, REG_STAT, '0, q);
		check(q, 32'h0);
		bus(1'b1, 6'h20, 32'hffffffff, q);
		bus(1'b0, 6'h20, '0, q);
		check(q, 32'h0);
		// readback of the settings registers, upper bits unused
		bus(1'b1, REG_ADDR, 32'h5555a5a5, q);
		bus(1'b0, REG_ADDR, '0, q);
		check(q, 32'ha5a5);
		bus(1'b1, REG_DATA, 32'h1c3, q);
		bus(1'b0, REG_DATA, '0, q);
		check(q, 32'hc3);
		bus(1'b1, REG_CTRL, 32'he, q);
		bus(1'b0, REG_CTRL, '0, q);
		check(q, 32'he);
		$display("test regs done");
	endtask : test_regs
	// long-pulse erase, with a start while busy that must be ignored
	task test_erase;
		logic [31:0] q;
		bus(1'b1, REG_ADDR, 32'h0100, q);
		bus(1'b1, REG_CTRL, 32'h1 << CTRL_START | 32'h1 << CTRL_ERASE | 32'h1 << CTRL_LONG, q);
		bus(1'b1, REG_CTRL, 32'h1 << CTRL_START, q);
		// the refused write left the mode alone, start reads back zero
		bus(1'b0, REG_CTRL, '0, q);
		check(q, 32'ha);
		bus(1'b0, REG_STAT, '0, q);
		check(q[2:0], 3'b001);
		wait_done(q);
		check(q[2:0], 3'b010);
		check(q[25:16], 10'd1);
		check(n_pulse, 0);
		check(last_w >= SEL && last_w <= SEL + 1, 1'b1);
		check(viol & 18'h3f102, 18'h0);
		$display("test erase done");
	endtask : test_erase
	// program one unit with the additional pulse
	task test_program;
		logic [31:0] q;
		bus(1'b1, REG_DATA, 32'h5a, q);
		bus(1'b1, REG_CTRL, 32'h1 << CTRL_START | 32'h1 << CTRL_EXTRA, q);
		wait_done(q);
		check(q[2:0], 3'b010);
		check(n_fill, 128);
		check(n_pulse, 2);
		check(last_w >= SP10_CYC * 4 / 5 && last_w <= SP10_CYC * 6 / 5, 1'b1);
		check(viol & 18'h7fe, 18'h0);
		$display("test program done");
	endtask : test_program
	// verdict and end of run
	task finish_test;
		$display("comparisons %0d mismatches %0d", compares, n_mismatch);
		if (n_mismatch == 0 && compares > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask : finish_test
	// clock
	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end
	// watchdog
	initial begin
		#1200000;
		n_mismatch++;
		finish_test();
	end
	// main sequence
	initial begin
		{rst_n, read, write, address, wdata, n_mismatch, compares} = '0;
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		test_regs();
		test_erase();
		test_program();
		finish_test();
	end
endmodule : testbench
